// ---- ulm_baud.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulm_baud #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Divisor and 16x tick
   input wire logic [W-1:0] i_divisor,
   output logic o_tick
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } ulm_baud_t;
   ulm_baud_t s, next_s;

   assign o_tick = s.tick;

   // Divisor 0 behaves as 1 rather than stalling the line
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (i_divisor <= W'(1) || s.cnt >= i_divisor - W'(1)) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + W'(1);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule // ulm_baud
`default_nettype wire

// ---- ulm_core.sv ----
// Operation
// - Outside loop-back, the send-break bit forces the serial output low whatever the transmitter does.
// - Divisor-select picks divisor latches, else data and irq enable.
// - Stick parity only acts when parity is enabled.
// - Parity select one means even, zero means odd, both directions.
// - Parity enable adds a parity bit on send and checks on receive.
// - Stop select: one stop, else two, or one and a half at five bits.
// - Word length field gives five, six, seven or eight data bits.
// - Loop-back feeds carrier, set-ready, clear-to-send from user_output_two, terminal, request.
// - Modem control bits 1 and 0 drive active-low request and terminal outputs.
// - User output bits are stored and read back, driving no pin; user_output_two feeds carrier in loop-back.
// - Transmitter-empty reads one only with holding and shift both empty.
// - Holding-empty flag follows the holding store, one after reset.
// - Buffer error flag set when held data carries parity, framing or break.
// - Break, framing, parity and overrun flags are set by receive errors.
// - Ready flag shows that the receive buffer holds data.
// - Outside loop-back, status bits show inverted modem input levels.
// - Change flags record modem line changes since the last status read.
// - Ring status and ring trailing-edge flag always read zero.
// - Eight-bit scratch field reads back what software wrote.
// - Two divisor bytes form one sixteen-bit baud divisor.
// - Modem interrupt enable lets a modem change raise the interrupt.
`timescale 1ns/1ps
`default_nettype none
module ulm_core #(
   parameter int FIFO_D = ulm_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   output logic o_tx_ready,
   // Serial line
   input wire logic i_serial_in,
   output logic o_serial_out,
   // Modem lines
   input wire logic i_carrier_detect_n,
   input wire logic i_set_ready_n,
   input wire logic i_clear_to_send_n,
   output logic o_request_to_send_n,
   output logic o_terminal_ready_n,
   output logic o_modem_irq
);
   import ulm_pkg::*;

   typedef struct packed {
      logic [7:0] lcr;
      logic [4:0] mcr;
      logic [3:0] ier;
      logic [7:0] dll;
      logic [7:0] dlm;
      logic [7:0] scr;
      logic [7:0] rbr;
      logic dr, oe, pe, fe, bi, rerr;
      logic [2:0] mprev;
      logic [2:0] mdelta;
      ulm_tx_t tx_st;
      logic [7:0] tx_sh;
      logic [2:0] tx_n;
      logic [5:0] tx_tk;
      logic tx_par;
      logic tx_line;
      logic pin;
      ulm_rx_t rx_st;
      logic [7:0] rx_sh;
      logic [2:0] rx_n;
      logic [5:0] rx_tk;
      logic rx_zero;
      logic rx_perr;
      logic [31:0] rdata;
      logic irq;
   } ulm_core_t;

   localparam ulm_core_t RST = '{
      lcr: LCR_RST, mcr: MCR_RST, ier: IER_RST, dll: DLL_RST,
      dlm: DLM_RST, scr: SCR_RST, tx_st: TX_IDLE, rx_st: RX_IDLE,
      tx_line: 1'b1, pin: 1'b1, default: '0};

   ulm_core_t s, next_s;
   logic tick, divisor_latch_select, loop, parity_enable_bit;
   logic [1:0] word_length_field;
   logic [2:0] last_n;
   logic [7:0] mask, rx_data;
   logic [5:0] stop_tk;
   logic [2:0] mnow;
   logic f_valid, f_ready, f_push, tx_holding_empty_flag, tx_all_empty_flag, rx_in;
   logic [7:0] f_data, lsr, msr;

   ////////////////////////////////////////////////////////////////
   // Parity of masked data, honouring select and stick bits
   function automatic logic par_of(input logic [7:0] d,
                                   input logic [7:0] l);
      if (l[LCR_STICK]) begin
         par_of = ~l[LCR_EVEN];
      end else if (l[LCR_EVEN]) begin
         par_of = ^d;
      end else begin
         par_of = ~(^d);
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // Baud tick and transmit holding store
   // sixteen-bit divisor
   ulm_baud #(.W(16)) u_baud (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_divisor({s.dlm, s.dll}),
      .o_tick(tick)
   );

   assign f_push = i_reg_wr & (i_reg_addr == OFS_DATA) & ~divisor_latch_select;

   ulm_fifo #(.W(8), .D(FIFO_D)) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_in_valid(f_push),
      .o_in_ready(o_tx_ready),
      .i_in_data(i_reg_wdata[7:0]),
      .o_out_valid(f_valid),
      .i_out_ready(f_ready),
      .o_out_data(f_data)
   );

   ////////////////////////////////////////////////////////////////
   // Decoded settings and status words
   assign divisor_latch_select = s.lcr[LCR_DIVISOR_LATCH_SELECT];
   assign loop = s.mcr[MCR_LOOP];
   assign parity_enable_bit = s.lcr[LCR_PEN];
   assign word_length_field = s.lcr[1:0];
   assign last_n = MIN_BITS_M1 + {1'b0, word_length_field};
   assign mask = 8'hff >> (2'h3 - word_length_field);
   assign rx_data = s.rx_sh >> (2'h3 - word_length_field);
   assign stop_tk = !s.lcr[LCR_STB] ? TK_BIT :
                    (word_length_field == 2'h0) ? TK_STOP15 : TK_STOP2;
   assign f_ready = (s.tx_st == TX_IDLE);
   assign tx_holding_empty_flag = ~f_valid;
   assign tx_all_empty_flag = tx_holding_empty_flag & (s.tx_st == TX_IDLE);
   assign rx_in = loop ? s.tx_line : i_serial_in;
   assign mnow = loop ? {s.mcr[MCR_USER_OUTPUT_TWO], s.mcr[MCR_DTR], s.mcr[MCR_RTS]}
                      : ~{i_carrier_detect_n, i_set_ready_n,
                          i_clear_to_send_n};
   assign lsr = {s.rerr, tx_all_empty_flag, tx_holding_empty_flag, s.bi, s.fe, s.pe, s.oe, s.dr};
   assign msr = {mnow[2], 1'b0, mnow[1], mnow[0],
                 s.mdelta[2], 1'b0, s.mdelta[1:0]};

   assign o_reg_rdata = s.rdata;
   assign o_serial_out = s.pin;
   assign o_request_to_send_n = s.mcr[MCR_RTS];
   assign o_terminal_ready_n = s.mcr[MCR_DTR];
   assign o_modem_irq = s.irq;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      next_s = s;

      // Register writes
      if (i_reg_wr) begin
         case (i_reg_addr)
            OFS_DATA: begin
               if (divisor_latch_select) begin
                  next_s.dll = i_reg_wdata[7:0];
               end
            end
            OFS_IER: begin
               if (divisor_latch_select) begin
                  next_s.dlm = i_reg_wdata[7:0];
               end else begin
                  next_s.ier = i_reg_wdata[3:0];
               end
            end
            OFS_LCR: next_s.lcr = i_reg_wdata[7:0];
            OFS_MCR: next_s.mcr = i_reg_wdata[4:0];
            OFS_SCR: next_s.scr = i_reg_wdata[7:0];
            default: next_s.scr = s.scr;
         endcase
      end

      // Register reads; clears come before hardware sets below
      if (i_reg_rd) begin
         case (i_reg_addr)
            OFS_DATA: begin
               next_s.rdata = {24'h0, divisor_latch_select ? s.dll : s.rbr};
               if (!divisor_latch_select) begin
                  next_s.dr = 1'b0;
               end
            end
            OFS_IER: next_s.rdata = divisor_latch_select ? {24'h0, s.dlm}
                                         : {28'h0, s.ier};
            OFS_LCR: next_s.rdata = {24'h0, s.lcr};
            OFS_MCR: next_s.rdata = {27'h0, s.mcr};
            OFS_LSR: begin
               next_s.rdata = {24'h0, lsr};
               next_s.oe = 1'b0;
               next_s.pe = 1'b0;
               next_s.fe = 1'b0;
               next_s.bi = 1'b0;
               next_s.rerr = 1'b0;
            end
            OFS_MSR: begin
               next_s.rdata = {24'h0, msr};
               next_s.mdelta = 3'h0;
            end
            OFS_SCR: next_s.rdata = {24'h0, s.scr};
            default: next_s.rdata = 32'h0;
         endcase
      end

      next_s.mdelta = next_s.mdelta | (mnow ^ s.mprev);
      next_s.mprev = mnow;
      next_s.irq = s.ier[IER_MODEM] & (|s.mdelta);

      // Transmitter
      if (s.tx_st == TX_IDLE && f_valid) begin
         next_s.tx_st = TX_START;
         next_s.tx_sh = f_data;
         next_s.tx_par = par_of(f_data & mask, s.lcr);
         next_s.tx_tk = 6'h0;
      end else if (tick && s.tx_st != TX_IDLE) begin
         next_s.tx_tk = s.tx_tk + 6'h1;
         if (s.tx_st == TX_STOP) begin
            if (s.tx_tk == stop_tk - 6'h1) begin
               next_s.tx_st = TX_IDLE;
            end
         end else if (s.tx_tk == TK_BIT - 6'h1) begin
            next_s.tx_tk = 6'h0;
            case (s.tx_st)
               TX_START: begin
                  next_s.tx_st = TX_DATA;
                  next_s.tx_n = 3'h0;
               end
               TX_DATA: begin
                  next_s.tx_sh = s.tx_sh >> 1;
                  next_s.tx_n = s.tx_n + 3'h1;
                  if (s.tx_n == last_n) begin
                     next_s.tx_st = parity_enable_bit ? TX_PAR : TX_STOP;
                  end
               end
               default: next_s.tx_st = TX_STOP;
            endcase
         end
      end

      case (s.tx_st)
         TX_START: next_s.tx_line = 1'b0;
         TX_DATA: next_s.tx_line = s.tx_sh[0];
         TX_PAR: next_s.tx_line = s.tx_par;
         default: next_s.tx_line = 1'b1;
      endcase
      if (s.lcr[LCR_BRK]) begin
         next_s.tx_line = 1'b0;
      end
      // Loop-back keeps the pin marking so the far end sees nothing
      next_s.pin = loop ? 1'b1 : next_s.tx_line;

      // Receiver
      if (s.rx_st == RX_WAIT) begin
         if (rx_in) begin
            next_s.rx_st = RX_IDLE;
         end
      end else if (tick) begin
         next_s.rx_tk = s.rx_tk + 6'h1;
         case (s.rx_st)
            RX_IDLE: begin
               next_s.rx_tk = 6'h0;
               if (!rx_in) begin
                  next_s.rx_st = RX_START;
               end
            end
            RX_START: begin
               if (s.rx_tk == TK_HALF - 6'h1) begin
                  next_s.rx_tk = 6'h0;
                  next_s.rx_n = 3'h0;
                  next_s.rx_zero = 1'b1;
                  next_s.rx_perr = 1'b0;
                  next_s.rx_st = rx_in ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (s.rx_tk == TK_BIT - 6'h1) begin
                  next_s.rx_tk = 6'h0;
                  next_s.rx_sh = {rx_in, s.rx_sh[7:1]};
                  next_s.rx_zero = s.rx_zero & ~rx_in;
                  next_s.rx_n = s.rx_n + 3'h1;
                  if (s.rx_n == last_n) begin
                     next_s.rx_st = parity_enable_bit ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (s.rx_tk == TK_BIT - 6'h1) begin
                  next_s.rx_tk = 6'h0;
                  next_s.rx_zero = s.rx_zero & ~rx_in;
                  next_s.rx_perr = rx_in ^ par_of(rx_data, s.lcr);
                  next_s.rx_st = RX_STOP;
               end
            end
            RX_STOP: begin
               if (s.rx_tk == TK_BIT - 6'h1) begin
                  next_s.rbr = rx_data;
                  next_s.dr = 1'b1;
                  next_s.oe = next_s.oe | s.dr;
                  next_s.pe = next_s.pe | s.rx_perr;
                  next_s.fe = next_s.fe | ~rx_in;
                  next_s.bi = next_s.bi | (s.rx_zero & ~rx_in);
                  next_s.rerr = next_s.rerr | s.rx_perr | ~rx_in;
                  next_s.rx_st = rx_in ? RX_IDLE : RX_WAIT;
               end
            end
            default: next_s.rx_st = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= RST;
      end else begin
         s <= next_s;
      end
   end
endmodule // ulm_core
`default_nettype wire

// ---- ulm_core_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulm_core_chk (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [31:0] o_reg_rdata,
   // Serial and modem lines
   input wire logic o_serial_out,
   input wire logic i_carrier_detect_n,
   input wire logic i_set_ready_n,
   input wire logic i_clear_to_send_n,
   input wire logic o_request_to_send_n,
   input wire logic o_terminal_ready_n
);
   import ulm_pkg::*;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);
   logic brk;
   logic [4:0] mcr;
   logic [7:0] watch;
   // Shadows rebuilt from writes, since no register is visible here
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         brk <= 1'b0;
         mcr <= MCR_RST;
      end else begin
         if (i_reg_wr && i_reg_addr == OFS_LCR)
            brk <= i_reg_wdata[LCR_BRK];
         if (i_reg_wr && i_reg_addr == OFS_MCR)
            mcr <= i_reg_wdata[4:0];
      end
   end
   assign watch = {mcr, i_carrier_detect_n, i_set_ready_n, i_clear_to_send_n};
   ////////////////////////////////////////
   sequence s_rd(logic [7:0] a);
      i_reg_rd && i_reg_addr == a;
   endsequence
   // Status needs a few quiet cycles to settle through its pipeline
   sequence s_quiet;
      $stable(watch) [*4];
   endsequence
   property p_mctl;
      i_reg_wr && i_reg_addr == OFS_MCR && !i_reg_wdata[MCR_LOOP] |=>
         {o_request_to_send_n, o_terminal_ready_n} == $past(i_reg_wdata[1:0]);
   endproperty
   a_mctl: assert property (p_mctl)
      else $error("modem control outputs wrong");
   property p_brk;
      (brk && !mcr[MCR_LOOP]) [*2] |-> !o_serial_out;
   endproperty
   a_brk: assert property (p_brk)
      else $error("serial output not held low in break");
   property p_scr;
      i_reg_wr && i_reg_addr == OFS_SCR ##1 !i_reg_wr ##1 s_rd(OFS_SCR) |=>
         o_reg_rdata == {24'h0, $past(i_reg_wdata[7:0], 3)};
   endproperty
   a_scr: assert property (p_scr)
      else $error("scratch readback wrong");
   property p_unmap;
      s_rd(8'h88) |=> o_reg_rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_ring;
      s_rd(OFS_MSR) |=> o_reg_rdata[6] == 1'b0 && o_reg_rdata[2] == 1'b0;
   endproperty
   a_ring: assert property (p_ring)
      else $error("ring bits set");
   property p_loop;
      s_quiet ##0 s_rd(OFS_MSR) ##0 mcr[MCR_LOOP] |=> o_reg_rdata[7:4] ==
         {$past(mcr[3]), 1'b0, $past(mcr[0]), $past(mcr[1])};
   endproperty
   a_loop: assert property (p_loop)
      else $error("loop-back status wrong");
   property p_stat;
      s_quiet ##0 s_rd(OFS_MSR) ##0 !mcr[MCR_LOOP] |=> o_reg_rdata[7:4] ==
         {~$past(watch[2]), 1'b0, ~$past(watch[1]), ~$past(watch[0])};
   endproperty
   a_stat: assert property (p_stat)
      else $error("modem status levels wrong");
   property p_dclr;
      s_quiet ##0 s_rd(OFS_MSR) ##1 $stable(watch) [*2] ##0 s_rd(OFS_MSR)
         |=> o_reg_rdata[3:0] == 4'h0;
   endproperty
   a_dclr: assert property (p_dclr)
      else $error("change flags not cleared by read");
   property p_lsr;
      s_rd(OFS_LSR) |=> !(o_reg_rdata[6] && !o_reg_rdata[5]);
   endproperty
   a_lsr: assert property (p_lsr)
      else $error("transmitter empty while holding full");
endmodule // ulm_core_chk
bind ulm_core ulm_core_chk i_ulm_core_chk (.*);
`default_nettype wire

// ---- ulm_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulm_core_tb;
   import ulm_pkg::*;
   logic i_clk_sys, i_rst_b, i_reg_wr, i_reg_rd, o_tx_ready, o_serial_out;
   logic serial_in, rts_n, dtr_n, irq;
   logic [7:0] i_reg_addr, bit_cycles;
   logic [31:0] i_reg_wdata, o_reg_rdata, v;
   logic [2:0] modem_n;
   int n_errors, checked, cyc;
   ulm_core i_ulm_core (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_tx_ready(o_tx_ready), .i_serial_in(serial_in),
      .o_serial_out(o_serial_out), .i_carrier_detect_n(modem_n[2]),
      .i_set_ready_n(modem_n[1]), .i_clear_to_send_n(modem_n[0]),
      .o_request_to_send_n(rts_n), .o_terminal_ready_n(dtr_n),
      .o_modem_irq(irq));
   ulm_remote i_ulm_remote (.i_clk_sys(i_clk_sys), .i_bit_cycles(bit_cycles),
      .i_serial_out(o_serial_out), .o_serial_in(serial_in),
      .o_modem_n(modem_n));
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc > 30000) begin
         n_errors++;
         end_of_test;
      end
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("Counts: %0d compares, %0d mismatches", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bus tasks start at a falling edge and leave an idle cycle behind
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      @(negedge i_clk_sys);
      i_reg_wr = 1'b0;
      @(negedge i_clk_sys);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      @(negedge i_clk_sys);
      i_reg_rd = 1'b0;
      check(o_reg_rdata, exp);
      @(negedge i_clk_sys);
   endtask
   function automatic logic par(input logic [7:0] d, input logic [7:0] lc);
      return lc[5] ? ~lc[4] : ^d ^ ~lc[4];
   endfunction
   function automatic int frame(input logic [7:0] lc);
      return (6 + lc[1:0] + lc[3]) * 16 +
         (lc[2] ? (lc[1:0] == 2'b00 ? 24 : 32) : 16);
   endfunction
   ////////////////////////////////////////
   task automatic tx_burst(input logic [7:0] lc);
      logic [7:0] d[5];
      logic [7:0] got;
      logic p;
      realtime t[5];
      int nb;
      nb = 5 + lc[1:0];
      wr(OFS_LCR, {24'h0, lc});
      fork
         begin
            for (int i = 0; i < 5; i++) begin
               d[i] = 8'($urandom) & (8'hff >> (3 - lc[1:0]));
               wr(OFS_DATA, {24'h0, d[i]});
            end
            check(o_tx_ready, 1'b0);
            rdc(OFS_LSR, 32'h0);
         end
         for (int i = 0; i < 5; i++) begin
            i_ulm_remote.take(nb, lc[3], got, p, t[i]);
            check(got, d[i]);
            check(p, lc[3] ? par(d[i], lc) : 1'b0);
            if (i > 0)
               check(int'((t[i] - t[i-1]) / 100.0) - frame(lc) inside {[0:3]},
                  1'b1);
         end
      join
      repeat (40) @(negedge i_clk_sys);
      rdc(OFS_LSR, 32'h60);
   endtask
   ////////////////////////////////////////
   initial begin
      logic [7:0] lc;
      logic [7:0] d;
      logic [2:0] m, pv;
      logic [7:0] cfg[4];
      cfg = '{8'h3b, 8'h04, 8'h20, 8'h1e};
      {i_rst_b, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
      bit_cycles = 8'h10;
      {n_errors, checked, cyc} = '0;
      v = $urandom(67);
      repeat (8) @(negedge i_clk_sys);
      i_rst_b = 1'b1;
      @(negedge i_clk_sys);
      rdc(OFS_LCR, 32'h0);
      rdc(OFS_LSR, 32'h60);
      rdc(8'h88, 32'h0);
      check({o_serial_out, rts_n, dtr_n, o_tx_ready}, 4'b1001);
      $display("Reset test done");
      pv = 3'h0;
      for (int i = 0; i < 4; i++) begin
         v = {$urandom, 2'(i)};
         wr(OFS_SCR, v);
         rdc(OFS_SCR, {24'h0, v[7:0]});
         wr(OFS_MCR, {28'h0, v[3:0]});
         rdc(OFS_MCR, {28'h0, v[3:0]});
         check({rts_n, dtr_n}, v[1:0]);
         // Leaving loop-back is itself a change of the looped levels
         rdc(OFS_MSR, {28'h0, pv[2], 1'b0, pv[1:0]});
         wr(OFS_MCR, {27'h1, v[3:0]});
         repeat (5) @(negedge i_clk_sys);
         rdc(OFS_MSR, {24'h0, v[3], 1'b0, v[0], v[1],
            v[3], 1'b0, v[0], v[1]});
         rdc(OFS_MSR, {24'h0, v[3], 1'b0, v[0], v[1], 4'h0});
         pv = {v[3], v[0], v[1]};
      end
      wr(OFS_MCR, 32'h0);
      rdc(OFS_MSR, {28'h0, pv[2], 1'b0, pv[1:0]});
      wr(OFS_LSR, 32'h0);
      rdc(OFS_LSR, 32'h60);
      $display("Register test done");
      wr(OFS_IER, 32'h8);
      rdc(OFS_IER, 32'h8);
      pv = 3'h7;
      for (int i = 0; i < 6; i++) begin
         m = (i == 0) ? 3'h2 : 3'($urandom);
         i_ulm_remote.set_lines(m);
         repeat (6) @(negedge i_clk_sys);
         check(irq, m != pv);
         rdc(OFS_MSR, {24'h0, ~m[2], 1'b0, ~m[1:0], m[2] ^ pv[2], 1'b0,
            m[1:0] ^ pv[1:0]});
         pv = m;
      end
      $display("Modem test done");
      wr(OFS_LCR, 32'h40);
      check(o_serial_out, 1'b0);
      wr(OFS_LCR, 32'h0);
      check(o_serial_out, 1'b1);
      for (int i = 0; i < 4; i++)
         tx_burst(cfg[i]);
      $display("Transmit test done");
      wr(OFS_LCR, 32'h1b);
      d = 8'($urandom);
      i_ulm_remote.send(d, 8, 1'b1, par(d, 8'h1b));
      rdc(OFS_LSR, 32'h61);
      rdc(OFS_DATA, {24'h0, d});
      i_ulm_remote.send(d, 8, 1'b1, ~par(d, 8'h1b));
      rdc(OFS_LSR, 32'he5);
      rdc(OFS_DATA, {24'h0, d});
      i_ulm_remote.hold_low(200);
      repeat (4) @(negedge i_clk_sys);
      rdc(OFS_LSR, 32'hf9);
      rdc(OFS_LSR, 32'h61);
      rdc(OFS_DATA, 32'h0);
      $display("Receive test done");
      end_of_test;
   end
endmodule // ulm_core_tb
`default_nettype wire

// ---- ulm_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulm_fifo #(
   parameter int W = 8,
   parameter int D = ulm_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   import ulm_pkg::*;
   // Depth must be a power of two so the pointers wrap on their own
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = AW + 1;
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [CW-1:0] cnt;
   } ulm_fifo_t;
   ulm_fifo_t s, next_s;
   logic push, pop;

   assign o_in_ready = (s.cnt != CW'(D));
   assign o_out_valid = (s.cnt != '0);
   assign o_out_data = s.mem[s.rd];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = i_in_data;
         next_s.wr = s.wr + AW'(1);
      end
      if (pop) begin
         next_s.rd = s.rd + AW'(1);
      end
      if (push && !pop) begin
         next_s.cnt = s.cnt + CW'(1);
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - CW'(1);
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule // ulm_fifo
`default_nettype wire

// ---- ulm_pkg.sv ----
package ulm_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_DATA = 8'h80;
   localparam logic [7:0] OFS_IER = 8'h84;
   localparam logic [7:0] OFS_LCR = 8'h8c;
   localparam logic [7:0] OFS_MCR = 8'h90;
   localparam logic [7:0] OFS_LSR = 8'h94;
   localparam logic [7:0] OFS_MSR = 8'h98;
   localparam logic [7:0] OFS_SCR = 8'h9c;
   // Line control fields
   localparam int LCR_DIVISOR_LATCH_SELECT = 7;
   localparam int LCR_BRK = 6;
   localparam int LCR_STICK = 5;
   localparam int LCR_EVEN = 4;
   localparam int LCR_PEN = 3;
   localparam int LCR_STB = 2;
   // Modem control fields, and the modem interrupt enable bit
   localparam int MCR_LOOP = 4;
   localparam int MCR_USER_OUTPUT_TWO = 3;
   localparam int MCR_RTS = 1;
   localparam int MCR_DTR = 0;
   localparam int IER_MODEM = 3;
   // Values after reset
   localparam logic [7:0] LCR_RST = 8'h00;
   localparam logic [4:0] MCR_RST = 5'h00;
   localparam logic [3:0] IER_RST = 4'h0;
   localparam logic [7:0] DLL_RST = 8'h01;
   localparam logic [7:0] DLM_RST = 8'h00;
   localparam logic [7:0] SCR_RST = 8'h00;
   // Oversampling counts in baud ticks, minimum word length less one, FIFO depth
   localparam logic [5:0] TK_BIT = 6'h10;
   localparam logic [5:0] TK_HALF = 6'h08;
   localparam logic [5:0] TK_STOP15 = 6'h18;
   localparam logic [5:0] TK_STOP2 = 6'h20;
   localparam logic [2:0] MIN_BITS_M1 = 3'h4;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
      TX_PAR = 3'b011, TX_STOP = 3'b100
   } ulm_tx_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
      RX_PAR = 3'b011, RX_STOP = 3'b100, RX_WAIT = 3'b101
   } ulm_rx_t;
endpackage

// ---- ulm_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module ulm_remote (
   // Clock and bit length
   input wire logic i_clk_sys,
   input wire logic [7:0] i_bit_cycles,
   // Serial line
   input wire logic i_serial_out,
   output logic o_serial_in,
   // Modem lines: carrier, set-ready, clear-to-send
   output logic [2:0] o_modem_n
);
   initial begin
      o_serial_in = 1'b1;
      o_modem_n = 3'h7;
   end
   task automatic set_lines(input logic [2:0] m);
      @(negedge i_clk_sys);
      o_modem_n = m;
   endtask
   // Parity bit comes from the caller so that it can be made wrong
   task automatic send(input logic [7:0] d, input int nb, input logic parity_enable_bit,
      input logic p);
      @(negedge i_clk_sys);
      o_serial_in = 1'b0;
      repeat (i_bit_cycles) @(negedge i_clk_sys);
      for (int i = 0; i < nb + parity_enable_bit; i++) begin
         o_serial_in = (i < nb) ? d[i] : p;
         repeat (i_bit_cycles) @(negedge i_clk_sys);
      end
      o_serial_in = 1'b1;
      repeat (i_bit_cycles) @(negedge i_clk_sys);
   endtask
   task automatic hold_low(input int n);
      @(negedge i_clk_sys);
      o_serial_in = 1'b0;
      repeat (n) @(negedge i_clk_sys);
      o_serial_in = 1'b1;
   endtask
   ////////////////////////////////////////
   // Returns at mid stop bit, before the next start can begin
   task automatic take(input int nb, input logic parity_enable_bit, output logic [7:0] d,
      output logic p, output realtime t);
      int k;
      d = 8'h00;
      p = 1'b0;
      k = 0;
      while (i_serial_out !== 1'b0 && k < 20000) begin
         @(posedge i_clk_sys);
         k++;
      end
      t = $realtime;
      repeat (i_bit_cycles / 2) @(posedge i_clk_sys);
      for (int i = 0; i < nb + parity_enable_bit; i++) begin
         repeat (i_bit_cycles) @(posedge i_clk_sys);
         if (i < nb)
            d[i] = i_serial_out;
         else
            p = i_serial_out;
      end
      repeat (i_bit_cycles) @(posedge i_clk_sys);
   endtask
endmodule // ulm_remote
`default_nettype wire
